// File: rtl/hcs_regs.sv
// Purpose: host command/status register with overrun tally and interrupt
// Assumes: AXI4-Lite slave on aclk, synchronous active-low reset
// Notes:   periodic-list done and end-of-frame come from schedule logic on aclk
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
module hcs_regs
	import hcs_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic        frame_end,
	input  wire logic        periodic_done,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [15:0]      cmd_bits,
	output logic             overrun_pulse,
	output logic             irq
);
	logic [15:0]            cmd_q;
	logic [15:0]            cmd_d;
	logic [HCS_IRQ_W-1:0]   irq_status_q;
	logic [HCS_IRQ_W-1:0]   irq_status_d;
	logic [HCS_IRQ_W-1:0]   irq_mask_q;
	logic                   aw_held_q;
	logic [7:0]             aw_addr_q;
	logic                   w_held_q;
	logic [31:0]            w_data_q;
	logic [3:0]             w_strb_q;
	logic                   bvalid_q;
	logic [1:0]             bresp_q;
	logic                   rvalid_q;
	logic [1:0]             rresp_q;
	logic [31:0]            rdata_q;
	logic [HCS_TALLY_W-1:0] overrun_frame_tally;

	wire        aw_take   = ce && s_axi_awvalid && !aw_held_q && !bvalid_q;
	wire        w_take    = ce && s_axi_wvalid && !w_held_q && !bvalid_q;
	wire        wr_go     = ce && aw_held_q && w_held_q && !bvalid_q;
	wire        ar_take   = ce && s_axi_arvalid && !rvalid_q;
	wire [31:0] strb_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
		{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	wire [31:0] wr_bits   = w_data_q & strb_mask;

	// both the read code and the write code reach the same register
	wire wr_cmd  = (aw_addr_q == hcs_byte_addr(HCS_CODE_WRITE))
		|| (aw_addr_q == hcs_byte_addr(HCS_CODE_READ));
	wire wr_isr  = aw_addr_q == hcs_byte_addr(HCS_IDX_IRQ_STATUS);
	wire wr_imsk = aw_addr_q == hcs_byte_addr(HCS_IDX_IRQ_MASK);
	wire wr_hit  = wr_cmd || wr_isr || wr_imsk;
	wire rd_cmd  = (s_axi_araddr == hcs_byte_addr(HCS_CODE_READ))
		|| (s_axi_araddr == hcs_byte_addr(HCS_CODE_WRITE));
	wire rd_isr  = s_axi_araddr == hcs_byte_addr(HCS_IDX_IRQ_STATUS);
	wire rd_imsk = s_axi_araddr == hcs_byte_addr(HCS_IDX_IRQ_MASK);

	wire overrun = frame_end && !periodic_done;

	// register image: command bits low, tally in its field, reserved zero
	wire [31:0] cmd_image = HCS_CMD_RESET | 32'(cmd_q)
		| (32'(overrun_frame_tally) << HCS_TALLY_LSB);

	hcs_tally #(
		.W(HCS_TALLY_W)
	) u_tally (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.bump    (overrun),
		.count   (overrun_frame_tally)
	);

	// writing one sets, writing zero keeps; software never clears here
	assign cmd_d = (wr_go && wr_cmd) ? (cmd_q | wr_bits[15:0]) : cmd_q;

	// overrun set wins over a same-cycle write-one-to-clear
	assign irq_status_d = (irq_status_q
		& ~((wr_go && wr_isr) ? wr_bits[HCS_IRQ_W-1:0] : '0))
		| (overrun ? HCS_IRQ_W'(1) << HCS_IRQ_OVERRUN : '0);

	// read word and responses are selected ahead of the flops that hold them
	wire        rd_hit  = rd_cmd || rd_isr || rd_imsk;
	wire [31:0] rd_word = rd_cmd ? cmd_image
		: rd_isr ? 32'(irq_status_q)
		: rd_imsk ? 32'(irq_mask_q)
		: 32'h0000_0000;
	wire [1:0]  rd_resp = rd_hit ? HCS_RESP_OKAY : HCS_RESP_SLVERR;
	wire [1:0]  wr_resp = wr_hit ? HCS_RESP_OKAY : HCS_RESP_SLVERR;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_q <= HCS_CMD_RESET[15:0];
		end else if (ce) begin
			cmd_q <= cmd_d;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status_q <= '0;
		end else if (ce) begin
			irq_status_q <= irq_status_d;
		end
	end

	// mask writes replace the whole field; only the status is write-one-to-clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_mask_q <= '0;
		end else if (ce && wr_go && wr_imsk) begin
			irq_mask_q <= wr_bits[HCS_IRQ_W-1:0];
		end
	end

	// address and data are captured apart so either may arrive first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			aw_addr_q <= '0;
		end else if (ce) begin
			if (aw_take) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_held_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_q <= 1'b0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else if (ce) begin
			if (w_take) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (wr_go) begin
				w_held_q <= 1'b0;
			end
		end
	end

	// the response holds off new writes, so one write at most is in flight
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= HCS_RESP_OKAY;
		end else if (ce) begin
			if (wr_go) begin
				bvalid_q <= 1'b1;
				bresp_q  <= wr_resp;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// reads only sample; nothing changes on a read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
		end else if (ce) begin
			if (ar_take) begin
				rvalid_q <= 1'b1;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// data stand unchanged from capture until the answer is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdata_q <= '0;
			rresp_q <= HCS_RESP_OKAY;
		end else if (ce && ar_take) begin
			rdata_q <= rd_word;
			rresp_q <= rd_resp;
		end
	end

	assign s_axi_awready = aw_take;
	assign s_axi_wready  = w_take;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = ar_take;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign cmd_bits      = cmd_q;
	assign overrun_pulse = overrun;
	assign irq           = |(irq_status_q & irq_mask_q);
endmodule : hcs_regs

// File: shared/hcs_pkg.sv
// Purpose: shared constants for the host command/status register block
// Assumes: AXI4-Lite register access, 32-bit data
// Notes:   command codes kept as indices; byte address is four times the low six bits of the index
package hcs_pkg;
	localparam logic [7:0]  HCS_CODE_READ      = 8'h02;
	localparam logic [7:0]  HCS_CODE_WRITE     = 8'h82;
	localparam logic [7:0]  HCS_IDX_CMD_STATUS = 8'h02;
	localparam logic [7:0]  HCS_IDX_IRQ_STATUS = 8'h03;
	localparam logic [7:0]  HCS_IDX_IRQ_MASK   = 8'h04;
	localparam logic [7:0]  HCS_IDX_OVR_STATUS = 8'h05;
	localparam int          HCS_ADDR_W         = 8;
	localparam logic [31:0] HCS_CMD_RESET      = 32'h0000_0000;
	localparam int          HCS_TALLY_LSB      = 16;
	localparam int          HCS_TALLY_W        = 2;
	localparam logic [31:0] HCS_CMD_WMASK      = 32'h0000_FFFF;
	localparam int          HCS_IRQ_OVERRUN    = 0;
	localparam int          HCS_IRQ_W          = 1;
	localparam logic [1:0]  HCS_RESP_OKAY      = 2'h0;
	localparam logic [1:0]  HCS_RESP_SLVERR    = 2'h2;

	function automatic logic [HCS_ADDR_W-1:0] hcs_byte_addr(input logic [7:0] idx);
		hcs_byte_addr = {idx[5:0], 2'h0};
	endfunction : hcs_byte_addr
endpackage : hcs_pkg

// File: rtl/hcs_tally.sv
// Purpose: wrapping overrun frame tally
// Assumes: one-cycle overrun pulses on aclk
// Notes:   width is a parameter; default is two bits
`timescale 1ns/1ps
module hcs_tally
	import hcs_pkg::*;
#(
	parameter int W = HCS_TALLY_W
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         ce,
	input  wire logic         bump,
	output logic      [W-1:0] count
);
	logic [W-1:0] count_q;
	logic [W-1:0] count_d;

	// natural overflow gives the wrap from all ones to zero
	assign count_d = bump ? W'(count_q + 1'b1) : count_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_q <= '0;
		end else if (ce) begin
			count_q <= count_d;
		end
	end

	assign count = count_q;
endmodule : hcs_tally

// File: testbench/hcs_regs_props.sv
// Purpose: bus and command register checks for hcs_regs
// Assumes: full word strobes on every write
// Notes: the tally is seen only through bus reads
`timescale 1ns/1ps
module hcs_regs_props
	import hcs_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        frame_end,
	input wire logic        periodic_done,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic [15:0] cmd_bits,
	input wire logic        overrun_pulse,
	input wire logic        irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire wr_cmd = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		&& s_axi_awaddr == 8'h08;
	wire rd_go  = s_axi_arvalid && s_axi_arready;
	AST_SET_ONLY: assert property ((cmd_bits & $past(cmd_bits)) == $past(cmd_bits))
		else $error("command bit cleared");
	AST_WR_CMD: assert property (wr_cmd |-> ##2 s_axi_bvalid
		&& cmd_bits == ($past(cmd_bits, 2) | $past(s_axi_wdata[15:0], 2)))
		else $error("command write not applied");
	AST_RD_LAT: assert property (rd_go |=> s_axi_rvalid)
		else $error("read answer late");
	AST_RD_DATA: assert property (rd_go && s_axi_araddr == 8'h08 |=>
		s_axi_rdata[15:0] == $past(cmd_bits) && s_axi_rdata[31:18] == 14'h0)
		else $error("command read data wrong");
	AST_OVR: assert property (overrun_pulse == (frame_end && !periodic_done))
		else $error("overrun detect wrong");
	// a rise needs a fresh overrun or a register write landing
	AST_IRQ_CAUSE: assert property ($rose(irq) |-> $past(overrun_pulse) || $rose(s_axi_bvalid))
		else $error("irq rose without cause");
	cover property (wr_cmd);
	cover property (overrun_pulse);
	cover property ($fell(irq));
endmodule : hcs_regs_props

// File: testbench/host_command_status_reg_test.sv
// Purpose: self-checking bench for hcs_regs
// Assumes: ce, bready, rready and wstrb held active
// Notes: bus answers are queued by the driver and checked by a monitor
`timescale 1ns/1ps
module host_command_status_reg_test
	import hcs_pkg::*;
;
	logic aclk = 0, aresetn = 0, fe = 0, pd = 0, awv = 0, wv = 0, arv = 0;
	logic awr, wr, bv, arr, rv, irq, op, p;
	logic [7:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rd, d;
	logic [1:0] br, rr, tl = 0;
	logic [15:0] cmd, cm = 0;
	logic [33:0] q[$];
	int n_mismatch = 0, n_checks = 0, i;
	hcs_regs u_hcs_regs(.aclk, .aresetn, .ce(1'h1), .frame_end(fe), .periodic_done(pd),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(1'h1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
		.s_axi_rready(1'h1), .cmd_bits(cmd), .overrun_pulse(op), .irq);
	initial forever #2 aclk = ~aclk;
	task conclude;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : conclude
	task chk(input string nm, input logic [33:0] s, input logic [33:0] e);
		n_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("unexpected %s exp %h seen %h", nm, e, s);
		end
	endtask : chk
	// ready is sampled at the rising edge that takes the item
	task wt(input int s);
		int k;
		for (k = 0; k < 50; k++) begin
			@(posedge aclk);
			if (s == 0 ? arr : s == 1 ? bv : rv) break;
		end
		if (k == 50) begin n_mismatch++; conclude(); end
	endtask : wt
	task wr_reg(input logic [7:0] a, input logic [31:0] v);
		logic da, dw;
		q.push_back(34'h0);
		awa <= a; wd <= v; awv <= 1'h1; wv <= 1'h1; da = 0; dw = 0;
		for (int k = 0; !(da && dw); k++) begin
			if (k > 50) begin n_mismatch++; conclude(); end
			@(posedge aclk); da = da | awr; dw = dw | wr;
			if (da) awv <= 1'h0;
			if (dw) wv <= 1'h0;
		end
		wt(1);
	endtask : wr_reg
	task rd_reg(input logic [7:0] a, input logic [33:0] e);
		q.push_back(e); ara <= a; arv <= 1'h1;
		wt(0); arv <= 1'h0;
		wt(2);
	endtask : rd_reg
	task ck_irq(input logic e);
		@(negedge aclk); chk("irq", {33'h0, irq}, {33'h0, e});
	endtask : ck_irq
	always @(posedge aclk) if (bv || rv) begin
		if (q.size() == 0) chk("resp", 34'h1, 34'h0);
		else chk("resp", bv ? {br, 32'h0} : {rr, rd}, q.pop_front());
	end
	initial begin
		void'($urandom(32'h244EF202));
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		rd_reg(8'h08, 34'h0);
		for (i = 0; i < 4; i++) begin
			d = (i == 2) ? 32'h0 : $urandom;
			wr_reg(8'h08, d); cm = cm | d[15:0];
			rd_reg(8'h08, {16'h0, tl, cm});
		end
		// five forced overruns make the two-bit tally wrap once
		for (i = 0; i < 8; i++) begin
			p = (i < 5) ? 1'h0 : 1'($urandom);
			fe <= 1'h1; pd <= p; @(posedge aclk); fe <= 1'h0; tl = tl + 2'(!p);
			rd_reg(8'h08, {16'h0, tl, cm});
		end
		ck_irq(1'h0);
		rd_reg(8'h0C, 34'h1);
		wr_reg(8'h10, 32'h1); ck_irq(1'h1);
		wr_reg(8'h0C, 32'h1); ck_irq(1'h0);
		rd_reg(8'h14, {HCS_RESP_SLVERR, 32'h0});
		conclude();
	end
endmodule : host_command_status_reg_test
bind hcs_regs hcs_regs_props u_p(.aclk, .aresetn, .frame_end, .periodic_done, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .cmd_bits,
	.overrun_pulse, .irq);
